// File: hw/nvmpb_pkg.sv
/*
  nvmpb_pkg: constants, types and the section lookup for the
  nonvolatile section checker and shared page buffer.
  assumes a 32-bit AHB-Lite register bus and a 16 KB flash array.
*/
package nvmpb_pkg;

  // ****************************************
  // memory map
  // ****************************************
  localparam logic [15:0] FLASH_BASE   = 16'h0000;
  localparam logic [15:0] FLASH_BYTES  = 16'h4000;
  localparam logic [15:0] EE_BASE      = 16'h4000;
  localparam logic [15:0] USER_BASE    = 16'h4100;
  localparam logic [15:0] REG_CMD      = 16'h5000;
  localparam logic [15:0] REG_LOCK     = 16'h5004;
  localparam logic [15:0] REG_STAT     = 16'h5008;
  localparam logic [6:0]  FLASH_BLOCKS = 7'h40;
  localparam logic [7:0]  BOOT_END_DEF = 8'h00;
  localparam logic [7:0]  CODE_END_DEF = 8'h00;

  // ****************************************
  // register fields
  // ****************************************
  localparam int LOCK_BOOT_BIT = 0;
  localparam int LOCK_CWP_BIT  = 1;
  localparam int STAT_FB_BIT   = 0;
  localparam int STAT_EB_BIT   = 1;
  localparam int STAT_REF_BIT  = 2;
  localparam int BUF_WORDS     = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NONE  = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_ERASE = 3'h2,
    CMD_ERWR  = 3'h3,
    CMD_CLEAR = 3'h4,
    CMD_CHIP  = 3'h5
  } nvmpb_cmd_e;

  typedef enum logic [1:0] {
    TG_FLASH = 2'h0,
    TG_EE    = 2'h1,
    TG_USER  = 2'h2,
    TG_NONE  = 2'h3
  } nvmpb_tgt_e;

  typedef enum logic [1:0] {
    RG_BOOT = 2'h0,
    RG_CODE = 2'h1,
    RG_DATA = 2'h2
  } nvmpb_rgn_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_READ = 2'h3
  } nvmpb_st_e;

  typedef struct packed {
    logic                 req;
    nvmpb_cmd_e           cmd;
    nvmpb_tgt_e           tgt;
    logic [7:0]           page;
    logic [BUF_WORDS-1:0] mark;
  } nvmpb_arr_s;

  // section of a 256-byte flash block
  function automatic nvmpb_rgn_e nvmpb_region(input logic [5:0] blk,
                                              input logic [7:0] be,
                                              input logic [7:0] ce);
    nvmpb_rgn_e r;
    r = RG_BOOT;
    if (be == 8'h00)
      r = RG_BOOT;
    else if ({2'b00, blk} < be)
      r = RG_BOOT;
    else if (ce == 8'h00)
      r = RG_CODE;
    else if (ce <= be)
      r = RG_DATA;
    else if ({2'b00, blk} < ce)
      r = RG_CODE;
    else
      r = RG_DATA;
    return r;
  endfunction : nvmpb_region

endpackage : nvmpb_pkg

// File: hw/nvmpb_top.sv
/*
  nvmpb_top: flash section protection, boot read lock, busy stalls
  and the shared AND-merging page buffer, as an AHB-Lite slave.
  assumes a single master, word transfers and an array that answers
  arr_rdata one cycle after arr_raddr and pulses arr_done per op.
*/
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: flash operations cover whole pages only
// R2: flash sections counted in 256-byte blocks
// R3: boot end zero makes all flash boot
// R4: code end zero: code to flash end
// R5: code end not above boot: data only
// R6: code spans boot end to code end
// R7: out-of-range fuse uses its default
// R8: boot writes code/data, code writes data
// R9: data-region code may never write
// R10: boot lock blocks boot reads and fetches
// R11: lock set from boot, acts outside boot
// R12: code write protect freezes code region
// R13: eeprom touches only marked buffer words
// R14: user page kept across chip erase
// R15: debug port writes user page when locked
// R16: array access during operation waits
// R17: one buffer, one target at once
// R18: store address low bits pick buffer word
// R19: buffer word ANDs new with old
// R20: buffer refills ones on reset/op/clear/wake
// R21: controller checks busy flags before use
// R22: refused write changes nothing
module nvmpb_top
  import nvmpb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        debug_port,
  input  wire logic        dev_locked,
  input  wire logic        sleep_wake,
  input  wire logic [7:0]  boot_end_fuse,
  input  wire logic [7:0]  code_end_fuse,
  output logic [15:0]      arr_raddr,
  input  wire logic [31:0] arr_rdata,
  output nvmpb_arr_s       arr_ctl,
  output logic [511:0]     arr_buf,
  input  wire logic        arr_done
);

  // ****************************************
  // state
  // ****************************************
  nvmpb_st_e            state;
  logic [15:0]          a_addr;
  logic                 a_wr;
  logic                 a_fetch;
  logic                 a_dbg;
  logic                 a_hi;
  nvmpb_rgn_e           exec_rgn;
  logic                 boot_read_lock;
  logic                 code_region_write_protect;
  logic                 flash_busy_flag;
  logic                 eeprom_busy_flag;
  logic                 refused;
  nvmpb_tgt_e           buf_tgt;
  logic [7:0]           buf_page;
  logic [31:0]          pbuf [BUF_WORDS];
  logic [BUF_WORDS-1:0] mark;

  // ****************************************
  // decode
  // ****************************************
  wire logic       take     = hsel && htrans[1] && hready;
  wire logic       in_flash = a_hi && (a_addr < FLASH_BYTES);
  wire logic       in_ee    = a_hi && (a_addr[15:8] == EE_BASE[15:8]);
  wire logic       in_user  = a_hi && (a_addr[15:5] == USER_BASE[15:5]);
  wire logic       hit_cmd  = a_hi && (a_addr == REG_CMD);
  wire logic       hit_lock = a_hi && (a_addr == REG_LOCK);
  wire logic       hit_stat = a_hi && (a_addr == REG_STAT);
  wire nvmpb_tgt_e a_tgt    = in_flash ? TG_FLASH : in_ee ? TG_EE :
                              in_user ? TG_USER : TG_NONE;
  wire logic [3:0] a_idx    = a_addr[5:2]; // [R18]
  wire logic [7:0] a_page   = (a_tgt == TG_FLASH) ? a_addr[13:6] :
                              (a_tgt == TG_EE) ? {6'h00, a_addr[7:6]} : 8'h00;

  // fuses beyond the array fall back to defaults [R7]
  wire logic [7:0] eff_boot = (boot_end_fuse > {1'b0, FLASH_BLOCKS}) ?
                              BOOT_END_DEF : boot_end_fuse;
  wire logic [7:0] eff_code = (code_end_fuse > {1'b0, FLASH_BLOCKS}) ?
                              CODE_END_DEF : code_end_fuse;
  // section of the addressed block [R2] [R3] [R4] [R5] [R6]
  wire nvmpb_rgn_e a_rgn    = nvmpb_region(a_addr[13:8], eff_boot, eff_code);
  wire nvmpb_rgn_e buf_rgn  = nvmpb_region(buf_page[7:2], eff_boot, eff_code);

  // ****************************************
  // protection
  // ****************************************
  wire logic cpu_data  = !a_dbg && (exec_rgn == RG_DATA);
  wire logic sect_ok   = (exec_rgn == RG_BOOT && a_rgn != RG_BOOT) ||
                         (exec_rgn == RG_CODE && a_rgn == RG_DATA); // [R8]
  wire logic cwp_hit   = code_region_write_protect && a_rgn == RG_CODE;
  wire logic path_ok   = a_dbg ? (!dev_locked || a_tgt == TG_USER) : // [R15]
                         !cpu_data && (a_tgt != TG_FLASH || sect_ok); // [R9]
  wire logic same_tgt  = (buf_tgt == TG_NONE) || (buf_tgt == a_tgt); // [R17]
  wire logic wr_ok     = path_ok && same_tgt &&
                         !(a_tgt == TG_FLASH && cwp_hit); // [R12]
  wire logic rd_block  = boot_read_lock && in_flash && a_rgn == RG_BOOT &&
                         exec_rgn != RG_BOOT; // [R10] [R11]

  // ****************************************
  // commands
  // ****************************************
  wire logic [2:0] cmd_code = hwdata[2:0];
  wire logic is_page_op  = cmd_code == CMD_WRITE || cmd_code == CMD_ERASE ||
                           cmd_code == CMD_ERWR;
  wire logic buf_cwp     = code_region_write_protect &&
                           buf_tgt == TG_FLASH && buf_rgn == RG_CODE;
  wire logic cmd_ok      = !cpu_data && (
                           (is_page_op && buf_tgt != TG_NONE && !buf_cwp) ||
                           (cmd_code == CMD_CLEAR) ||
                           (cmd_code == CMD_CHIP && a_dbg));

  // ****************************************
  // data phase actions
  // ****************************************
  wire logic busy     = flash_busy_flag || eeprom_busy_flag;
  wire logic stall    = busy && (a_tgt != TG_NONE || hit_cmd); // [R16]
  wire logic acc_go   = (state == ST_WAIT) && !stall;
  wire logic mem_wr   = acc_go && a_wr && a_tgt != TG_NONE;
  wire logic store_en = mem_wr && wr_ok;
  wire logic st_ref   = mem_wr && !wr_ok; // [R22]
  wire logic cmd_wr   = acc_go && a_wr && hit_cmd;
  wire logic go_op    = cmd_wr && cmd_ok && cmd_code != CMD_CLEAR;
  wire logic clr_cmd  = cmd_wr && cmd_ok && cmd_code == CMD_CLEAR;
  wire logic cmd_ref  = cmd_wr && !cmd_ok;
  wire logic fill     = arr_done || clr_cmd || sleep_wake; // [R20]
  wire logic lock_wr  = acc_go && a_wr && hit_lock;
  wire logic stat_wr  = acc_go && a_wr && hit_stat;
  wire logic rd_mem   = acc_go && !a_wr && a_tgt != TG_NONE;
  wire logic rd_reg   = acc_go && !a_wr && a_tgt == TG_NONE;
  wire logic [31:0] reg_rd = hit_stat ? {29'h0, refused, eeprom_busy_flag,
                                         flash_busy_flag} :
                             hit_lock ? {30'h0, code_region_write_protect,
                                         boot_read_lock} : 32'h0;
  wire logic [31:0] pbuf_sel = pbuf[a_idx];

  // ****************************************
  // bus state machine
  // ****************************************
  nvmpb_st_e next_state;
  always_comb begin
    case (state)
      ST_IDLE: next_state = take ? ST_WAIT : ST_IDLE;
      ST_WAIT: next_state = !acc_go ? ST_WAIT : rd_mem ? ST_READ : ST_IDLE;
      ST_READ: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      state     <= next_state;
      hreadyout <= (next_state == ST_IDLE);
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr  <= 16'h0;
      a_wr    <= 1'b0;
      a_fetch <= 1'b0;
      a_dbg   <= 1'b0;
      a_hi    <= 1'b0;
    end else if (state == ST_IDLE && take) begin
      a_addr  <= {haddr[15:2], 2'b00};
      a_wr    <= hwrite;
      a_fetch <= !hprot[0];
      a_dbg   <= debug_port;
      a_hi    <= haddr[31:16] == 16'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      arr_raddr <= 16'h0;
    end else if (rd_mem) begin
      arr_raddr <= a_addr;
    end else if (rd_reg) begin
      hrdata <= reg_rd;
    end else if (state == ST_READ) begin
      hrdata <= rd_block ? 32'h0 : arr_rdata; // [R10]
    end
  end

  // track the section the processor executes from
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      exec_rgn <= RG_BOOT;
    else if (state == ST_READ && a_fetch && in_flash && !a_dbg && !rd_block)
      exec_rgn <= a_rgn; // [R11]
  end

  // ****************************************
  // control and status
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_read_lock            <= 1'b0;
      code_region_write_protect <= 1'b0;
    end else if (lock_wr) begin
      if (hwdata[LOCK_BOOT_BIT] && !a_dbg && exec_rgn == RG_BOOT)
        boot_read_lock <= 1'b1; // [R11]
      if (hwdata[LOCK_CWP_BIT])
        code_region_write_protect <= 1'b1; // [R12]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      refused <= 1'b0;
    else if (st_ref || cmd_ref)
      refused <= 1'b1;
    else if (stat_wr && hwdata[STAT_REF_BIT])
      refused <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_busy_flag  <= 1'b0;
      eeprom_busy_flag <= 1'b0;
    end else if (go_op) begin
      flash_busy_flag  <= buf_tgt == TG_FLASH || cmd_code == CMD_CHIP;
      eeprom_busy_flag <= buf_tgt != TG_FLASH || cmd_code == CMD_CHIP;
    end else if (arr_done) begin
      flash_busy_flag  <= 1'b0;
      eeprom_busy_flag <= 1'b0;
    end
  end

  // one-cycle command to the arrays
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arr_ctl <= '{req: 1'b0, cmd: CMD_NONE, tgt: TG_NONE, page: 8'h00,
                   mark: '0};
    end else if (go_op) begin
      arr_ctl.req  <= 1'b1;
      arr_ctl.cmd  <= nvmpb_cmd_e'(cmd_code);
      // chip erase leaves the user page alone [R14]
      arr_ctl.tgt  <= (cmd_code == CMD_CHIP) ? TG_NONE : buf_tgt;
      arr_ctl.page <= buf_page;
      // flash takes whole pages, eeprom only marked words [R1] [R13]
      arr_ctl.mark <= (buf_tgt == TG_FLASH) ? '1 : mark;
    end else begin
      arr_ctl.req <= 1'b0;
    end
  end

  // ****************************************
  // page buffer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_tgt  <= TG_NONE;
      buf_page <= 8'h00;
    end else if (fill) begin
      buf_tgt  <= TG_NONE;
    end else if (store_en) begin
      buf_tgt  <= a_tgt; // [R17]
      buf_page <= a_page;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUF_WORDS; gi++) begin : g_buf
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pbuf[gi] <= '1; // [R20]
          mark[gi] <= 1'b0;
        end else if (fill) begin
          pbuf[gi] <= '1; // [R20]
          mark[gi] <= 1'b0;
        end else if (store_en && a_idx == 4'(gi)) begin
          pbuf[gi] <= pbuf[gi] & hwdata; // [R19]
          mark[gi] <= 1'b1; // [R13]
        end
      end
      assign arr_buf[gi*32 +: 32] = pbuf[gi];
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  chk_busy_stalls: assert property ( // [R16]
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_WAIT && busy && a_tgt != TG_NONE) |=> !hreadyout)
    else $error("array access not stalled while busy");

  chk_done_refill: assert property ( // [R20]
    @(posedge hclk) disable iff (!hresetn)
    arr_done |=> (mark == '0 && pbuf[0] == '1 && buf_tgt == TG_NONE))
    else $error("page buffer not refilled after operation");

  chk_and_merge: assert property ( // [R19]
    @(posedge hclk) disable iff (!hresetn)
    (store_en && !fill) |=> pbuf[$past(a_idx)] ==
                            ($past(pbuf_sel) & $past(hwdata)))
    else $error("page buffer did not merge by and");

  chk_data_nowrite: assert property ( // [R9]
    @(posedge hclk) disable iff (!hresetn)
    (mem_wr && cpu_data) |=> refused && $stable(mark))
    else $error("write from data section accepted");

  chk_cwp_blocks: assert property ( // [R12]
    @(posedge hclk) disable iff (!hresetn)
    (mem_wr && a_tgt == TG_FLASH && cwp_hit && !fill) |=> $stable(mark))
    else $error("code section modified under write protect");

  chk_lock_read: assert property ( // [R10]
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_READ && rd_block) |=> (hrdata == 32'h0 && hreadyout))
    else $error("locked boot section readable");

  chk_boot_all: assert property ( // [R3]
    @(posedge hclk) disable iff (!hresetn)
    (eff_boot == 8'h00 && in_flash) |-> a_rgn == RG_BOOT)
    else $error("zero boot end did not make all flash boot");

  chk_single_op: assert property ( // [R17]
    @(posedge hclk) disable iff (!hresetn)
    arr_ctl.req |-> !$past(busy) && (flash_busy_flag || eeprom_busy_flag))
    else $error("operation started while another ran");

  chk_full_page: assert property ( // [R1]
    @(posedge hclk) disable iff (!hresetn)
    (arr_ctl.req && arr_ctl.tgt == TG_FLASH) |-> arr_ctl.mark == '1)
    else $error("partial flash page operation");

  chk_refuse_keep: assert property ( // [R22]
    @(posedge hclk) disable iff (!hresetn)
    (st_ref && !fill) |=> $stable(mark) && $stable(buf_tgt))
    else $error("refused write changed the page buffer");

  cov_flash_write: cover property (
    @(posedge hclk) disable iff (!hresetn)
    arr_ctl.req && arr_ctl.tgt == TG_FLASH);
  cov_ee_partial: cover property (
    @(posedge hclk) disable iff (!hresetn)
    arr_ctl.req && arr_ctl.tgt == TG_EE && arr_ctl.mark != '1);
  cov_busy_wait: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state == ST_WAIT && stall ##1 state == ST_WAIT);
  cov_locked_read: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state == ST_READ && rd_block);

endmodule : nvmpb_top

`default_nettype wire

// File: dv/nvmpb_arr_model.sv
/*
  nvmpb_arr_model: array stand-in with pattern read data and a timed done pulse.
  assumes arr_ctl.req pulses one cycle per accepted command.
*/
`timescale 1ns/1ps
`default_nettype none
module nvmpb_arr_model
  import nvmpb_pkg::*;
#(
  parameter int DONE_WAIT = 20
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] arr_raddr,
  input  wire nvmpb_arr_s  arr_ctl,
  output logic [31:0]      arr_rdata,
  output logic             arr_done
);
  // ****************************************
  // array read and operation timing
  // ****************************************
  logic [7:0] cnt;
  assign arr_rdata = {arr_raddr, ~arr_raddr};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt      <= 8'h00;
      arr_done <= 1'b0;
    end else begin
      arr_done <= (cnt == 8'h01);
      if (arr_ctl.req) begin
        cnt <= 8'(DONE_WAIT); // whole page op takes time
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : nvmpb_arr_model
`default_nettype wire

// File: dv/tb_top.sv
/*
  tb_top: AHB-Lite bench for the section checker and page buffer.
  assumes nvmpb_arr_model on the array side, single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nvmpb_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, arr_done;
  logic         debug_port, dev_locked, sleep_wake;
  logic [1:0]   htrans;
  logic [3:0]   hprot;
  logic [7:0]   be, ce;
  logic [15:0]  arr_raddr;
  logic [31:0]  haddr, hwdata, hrdata, arr_rdata, rdv;
  logic [511:0] arr_buf;
  nvmpb_arr_s   arr_ctl, lc;
  int           err_total, total_checks, wtv;

  nvmpb_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .debug_port(debug_port),
    .dev_locked(dev_locked), .sleep_wake(sleep_wake), .boot_end_fuse(be), .code_end_fuse(ce),
    .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_ctl(arr_ctl), .arr_buf(arr_buf),
    .arr_done(arr_done));
  nvmpb_arr_model #(.DONE_WAIT(20)) arr (.hclk(hclk), .hresetn(hresetn), .arr_raddr(arr_raddr),
    .arr_ctl(arr_ctl), .arr_rdata(arr_rdata), .arr_done(arr_done));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (arr_ctl.req === 1'b1) begin
      lc <= arr_ctl;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic f);
    int n;
    hsel   <= 1'b1;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hprot  <= {3'h0, ~f};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_total++;
      $display("[FAIL] %0t bus hang", $time);
      stop_test();
    end
    rdv = hrdata;
    wtv = n;
  endtask : ahb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    ahb(1'b0, a, 32'h0, 1'b0);
  endtask : rd
  task automatic fe(input logic [15:0] a);
    ahb(1'b0, a, 32'h0, 1'b1);
  endtask : fe
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(REG_STAT);
      n++;
    end while (rdv[1:0] !== 2'b00 && n < 100); // both busy flags low first
    if (rdv[1:0] !== 2'b00) begin
      err_total++;
      $display("[FAIL] %0t busy flags stuck", $time);
      stop_test();
    end
  endtask : idle
  task automatic cmd(input nvmpb_cmd_e c);
    idle();
    wr(REG_CMD, {29'h0, c});
    idle();
  endtask : cmd
  task automatic refchk(input logic e);
    rd(REG_STAT);
    chk({31'h0, rdv[2]}, {31'h0, e});
  endtask : refchk
  task automatic ones;
    chk({31'h0, arr_buf === {512{1'b1}}}, 32'h1);
  endtask : ones
  task automatic pr(input logic [7:0] b, input logic [7:0] c, input logic [15:0] x,
                    input logic [15:0] a, input logic ok);
    be <= b;
    ce <= c;
    @(posedge hclk);
    fe(x);
    wr(REG_STAT, 32'h4);
    wr(a, 32'h1234_5678);
    chk({31'h0, hresp}, 32'h0); // okay response
    refchk(~ok); // refusal flag
    chk(arr_buf[a[5:2]*32+:32], ok ? 32'h1234_5678 : 32'hffff_ffff); // buffer word stored, or left alone if refused
    cmd(CMD_CLEAR);
    ones(); // clear refills
  endtask : pr
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #400us;
    err_total++;
    stop_test();
  end
  initial begin
    {hsel, hwrite, debug_port, dev_locked, sleep_wake} = 5'h00;
    {htrans, hprot, haddr, hwdata} = '0;
    err_total = 0;
    total_checks = 0;
    be = 8'h04;
    ce = 8'h08;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, hreadyout}, 32'h1);
    chk(hrdata, 32'h0);
    chk({31'h0, arr_ctl.req}, 32'h0);
    ones(); // reset fills ones
    $display("test reset done");
    fe(16'h0000);
    wr(16'h2004, 32'hff00_ff00);
    wr(16'h2004, 32'h0f0f_0f0f);
    chk(arr_buf[63:32], 32'h0f00_0f00); // and-merge at word 1
    chk(arr_buf[31:0], 32'hffff_ffff); // word 0 untouched
    wr(REG_STAT, 32'h4);
    wr(16'h4004, 32'h0);
    refchk(1'b1); // second memory refused
    chk(arr_buf[63:32], 32'h0f00_0f00); // nothing changed
    $display("test merge done");
    idle();
    wr(REG_CMD, {29'h0, CMD_WRITE});
    rd(16'h0000);
    chk({31'h0, wtv > 19}, 32'h1); // read stalled by busy
    chk(rdv, 32'h0000_ffff); // read data after stall
    chk({30'h0, lc.tgt}, {30'h0, TG_FLASH});
    chk({29'h0, lc.cmd}, {29'h0, CMD_WRITE}); // page write
    chk({24'h0, lc.page}, 32'h80); // page of 0x2004
    chk({16'h0, lc.mark}, 32'hffff); // all words
    ones(); // refill after op
    $display("test command done");
    pr(8'h04, 8'h08, 16'h0000, 16'h0404, 1'b1); // boot to code
    pr(8'h04, 8'h08, 16'h0400, 16'h0804, 1'b1); // code to data
    pr(8'h04, 8'h08, 16'h0400, 16'h0408, 1'b0); // code to code
    pr(8'h04, 8'h08, 16'h0800, 16'h0808, 1'b0); // data caller
    pr(8'h04, 8'h08, 16'h0800, 16'h4008, 1'b0); // data to eeprom
    pr(8'h00, 8'h08, 16'h3f00, 16'h4008, 1'b1); // all boot
    pr(8'h00, 8'h08, 16'h3f00, 16'h3f04, 1'b0); // boot never written
    pr(8'h04, 8'h00, 16'h3f00, 16'h3f04, 1'b0); // code to end
    pr(8'h04, 8'h00, 16'h3f00, 16'h4008, 1'b1); // code to end
    pr(8'h08, 8'h04, 16'h3f00, 16'h4008, 1'b0); // data only
    pr(8'h08, 8'h04, 16'h0400, 16'h0804, 1'b1); // boot to data
    pr(8'h04, 8'h41, 16'h3f00, 16'h4008, 1'b1); // fuse default
    be <= 8'h04;
    ce <= 8'h08;
    $display("test regions done");
    fe(16'h0000);
    wr(16'h4008, 32'h0000_00aa);
    wr(16'h4014, 32'h0000_0055);
    cmd(CMD_ERWR);
    chk({30'h0, lc.tgt}, {30'h0, TG_EE});
    chk({16'h0, lc.mark}, 32'h0024); // marked words only
    wr(16'h4000, 32'h0000_0000);
    cmd(CMD_ERASE);
    chk({29'h0, lc.cmd}, {29'h0, CMD_ERASE}); // eeprom erase
    chk({16'h0, lc.mark}, 32'h0001); // one marked word
    $display("test eeprom done");
    dev_locked <= 1'b1;
    debug_port <= 1'b1;
    wr(16'h4104, 32'h0000_0011);
    chk(arr_buf[63:32], 32'h0000_0011); // locked debug store
    cmd(CMD_WRITE);
    chk({30'h0, lc.tgt}, {30'h0, TG_USER});
    chk({16'h0, lc.mark}, 32'h0002); // user page written as eeprom
    wr(REG_STAT, 32'h4);
    wr(16'h2004, 32'h0);
    refchk(1'b1); // locked debug flash store
    ones();
    dev_locked <= 1'b0;
    cmd(CMD_CHIP);
    chk({30'h0, lc.tgt}, {30'h0, TG_NONE}); // user page spared
    debug_port <= 1'b0;
    $display("test user done");
    fe(16'h0400);
    wr(REG_LOCK, 32'h1);
    rd(REG_LOCK);
    chk({31'h0, rdv[0]}, 32'h0); // lock only from boot
    fe(16'h0000);
    wr(REG_LOCK, 32'h3);
    rd(16'h0010);
    chk(rdv, 32'h0010_ffef); // no effect inside boot
    wr(REG_STAT, 32'h4);
    wr(16'h0404, 32'h0);
    refchk(1'b1); // code protect
    ones();
    fe(16'h0400);
    rd(16'h0010);
    chk(rdv, 32'h0); // boot read blocked
    wr(16'h0804, 32'h5a5a_5a5a);
    chk(arr_buf[63:32], 32'h5a5a_5a5a); // code writes data
    sleep_wake <= 1'b1;
    @(posedge hclk);
    sleep_wake <= 1'b0;
    repeat (2) @(posedge hclk);
    ones(); // wake refill
    wr(16'h0804, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ones(); // reset refill
    rd(REG_LOCK);
    chk({30'h0, rdv[1:0]}, 32'h0); // locks cleared by reset
    $display("test lock done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
